// ===== hdl/adsf_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsf_cfg.svh"

module adsf_top (
  // System clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,

  // Serial link, clocked by the host
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,

  // Converter core result
  input wire logic [`ADSF_RES_BITS-1:0] i_adc_code,

  // Converter control
  output logic o_conv_start,
  output logic o_input_mode_select,
  output logic o_odd_sign,
  output logic [1:0] o_channel_select,
  output logic o_polarity_select,

  // Power shutdown
  output logic o_power_down,
  output logic o_system_shutdown_out_n
);
  import adsf_pkg::*;

  // Picks the data-out bit for one position of the output sequence.
  // Position zero is the first result bit after the null bit.
  function automatic logic adsf_seq_bit(
    input logic [`ADSF_RES_BITS-1:0] w,
    input logic [`ADSF_POS_BITS-1:0] p,
    input logic msb_only,
    input logic bipolar,
    input logic shut
  );
    logic [3:0] msb_idx;
    logic [`ADSF_POS_BITS-1:0] lsb_off;
    logic in_msb;
    logic in_lsb;
    logic bit_v;
    msb_idx = `ADSF_RES_MSB - p[3:0];
    lsb_off = p - `ADSF_POS_MSB_END;
    in_msb = (p < `ADSF_POS_MSB_END);
    in_lsb = (p < `ADSF_POS_LSB_END);
    if (shut) begin
      bit_v = in_msb;
    end else if (in_msb) begin
      bit_v = w[msb_idx];
    end else if (msb_only) begin
      bit_v = 1'b0;
    end else if (in_lsb) begin
      bit_v = w[lsb_off[3:0]];
    end else begin
      bit_v = bipolar & w[`ADSF_SIGN_BIT];
    end
    return bit_v;
  endfunction : adsf_seq_bit

  // Reset release, system clock domain.
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // The frame state, result and output shifter are cleared whenever select is released, so every frame
  // starts from a known state even though the host clock stops between frames.
  wire link_clr = ~rst_sync_q | i_cs_n;

  // Crossing between the link clock and the system clock.
  adsf_xfer_if xfer ();

  // Frame state, rising edge of the link clock.
  adsf_state_t state_q;
  adsf_state_t state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [`ADSF_CMD_BITS-2:0] shift_q;
  logic [`ADSF_CMD_BITS-2:0] shift_d;
  logic [`ADSF_RES_BITS-1:0] word_q;

  // Values that survive from frame to frame on the link side.
  logic [`ADSF_CMD_BITS-1:0] cmd_q;
  logic cmd_tgl_q;
  logic req_meta_q;
  logic req_sync_q;
  logic ack_q;
  logic [`ADSF_RES_BITS-1:0] link_word_q;

  // Output shifter, falling edge of the link clock.
  logic out_on_q;
  logic out_bit_q;
  logic [`ADSF_POS_BITS-1:0] pos_q;

  // Decoded conditions.
  wire in_idle = (state_q == ADSF_ST_IDLE);
  wire in_cmd = (state_q == ADSF_ST_CMD);
  wire in_data = (state_q == ADSF_ST_DATA);
  wire start_seen = in_idle & i_din;
  wire cmd_last = in_cmd & (cnt_q == `ADSF_CMD_LAST);
  wire [`ADSF_CMD_BITS-1:0] cmd_full = {shift_q, i_din};
  wire new_snap = (req_sync_q != ack_q);
  wire pos_end = (pos_q == `ADSF_POS_LSB_END);
  wire [`ADSF_POS_BITS-1:0] pos_next = pos_q + `ADSF_POS_STEP;

  // Modes of the current frame's command.
  wire mode_msb_only = cmd_q[`ADSF_F_ORDER];
  wire mode_bipolar = ~cmd_q[`ADSF_F_POL];
  wire mode_shut = ~cmd_q[`ADSF_F_PD];

  wire seq_bit = adsf_seq_bit(word_q, pos_q, mode_msb_only, mode_bipolar, mode_shut);

  // Leading zeros before the start bit are ignored, which lets a byte host
  // pad its first byte and align the result to byte boundaries.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    unique case (state_q)
      ADSF_ST_IDLE: begin
        cnt_d = '0;
        if (start_seen) begin
          state_d = ADSF_ST_CMD;
        end
      end
      ADSF_ST_CMD: begin
        shift_d = cmd_full[`ADSF_CMD_BITS-2:0];
        cnt_d = cnt_q + `ADSF_CNT_STEP;
        if (cmd_last) begin
          state_d = ADSF_ST_DATA;
        end
      end
      ADSF_ST_DATA: begin
        cnt_d = cnt_q;
      end
      default: begin
        state_d = ADSF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      state_q <= ADSF_ST_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
    end
  end

  // The result of this frame is frozen at the last command bit, so the
  // word cannot change halfway through its own shifting.
  always_ff @(posedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      word_q <= '0;
    end else if (cmd_last) begin
      word_q <= link_word_q;
    end
  end

  // The command and its toggle are not cleared by select, so the system
  // side always reads a word that stays still after the toggle moves.
  always_ff @(posedge i_sclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cmd_q <= `ADSF_CMD_RST;
      cmd_tgl_q <= 1'b0;
    end else if (cmd_last) begin
      cmd_q <= cmd_full;
      cmd_tgl_q <= ~cmd_tgl_q;
    end
  end

  // Snapshot handshake, receiving end. The link clock only runs inside a
  // frame, so the word used is the newest that arrived by the command's end.
  always_ff @(posedge i_sclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= xfer.req;
      req_sync_q <= req_meta_q;
    end
  end

  always_ff @(posedge i_sclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ack_q <= 1'b0;
      link_word_q <= '0;
    end else if (new_snap) begin
      link_word_q <= xfer.snap;
      ack_q <= req_sync_q;
    end
  end

  // Data-out changes on falling edges so the host samples it on rising ones.
  // The first driven bit is a null zero, then the sequence follows.
  always_ff @(negedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      out_on_q <= 1'b0;
      out_bit_q <= 1'b0;
    end else if (in_data) begin
      out_on_q <= 1'b1;
      out_bit_q <= out_on_q & seq_bit;
    end
  end

  // The position stops at the end of the sequence; the fill then repeats.
  always_ff @(negedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      pos_q <= '0;
    end else if (in_data && out_on_q && !pos_end) begin
      pos_q <= pos_next;
    end
  end

  assign o_dout = out_bit_q;
  assign o_dout_oe = out_on_q;

  assign xfer.cmd = cmd_q;
  assign xfer.cmd_tgl = cmd_tgl_q;
  assign xfer.ack = ack_q;

  // System-side control, shutdown and snapshot source.
  adsf_core u_core (
    .i_mclk(i_mclk),
    .i_rst_n(rst_sync_q),
    .i_cs_n(i_cs_n),
    .i_adc_code(i_adc_code),
    .x(xfer.core),
    .o_conv_start(o_conv_start),
    .o_input_mode_select(o_input_mode_select),
    .o_odd_sign(o_odd_sign),
    .o_channel_select(o_channel_select),
    .o_polarity_select(o_polarity_select),
    .o_power_down(o_power_down),
    .o_system_shutdown_out_n(o_system_shutdown_out_n)
  );

endmodule : adsf_top

`default_nettype wire

// ===== hdl/adsf_cfg.svh
// Operation
// - Output-order bit one: result leaves data-out most significant bit first.
// - With output-order bit one, zeros follow the last result bit for every further clock.
// - Output-order bit zero: result MSB first, then again LSB first.
// - Bipolar with order bit zero: sign bit fills after the final MSB.
// - A zero power-down bit in the command enters power shutdown.
// - In shutdown, with select held, twelve ones then zeros are shifted out.
// - Releasing chip select puts data-out into high impedance.
// - Shutdown lasts until the next select cycle; conversion starts without warm-up.
// - The system-shutdown output goes low when shutdown is activated.
// - The system-shutdown output returns high when the next select cycle begins.
// - In a three-byte exchange bits 11 to 8 end the second byte.
// - In a three-byte exchange bits 7 to 0 form the third byte.
// - Four bits after the start bit select the input multiplexer setting.
// - Polarity bit one gives unipolar, zero gives bipolar sign-carrying conversion.
`ifndef ADSF_CFG_SVH
`define ADSF_CFG_SVH

// Command word after the start bit, first received bit highest.
`define ADSF_CMD_BITS 7
`define ADSF_CMD_LAST 3'h6
`define ADSF_CNT_STEP 3'h1
`define ADSF_F_MODE 6
`define ADSF_F_ODD 5
`define ADSF_F_SEL_HI 4
`define ADSF_F_SEL_LO 3
`define ADSF_F_POL 2
`define ADSF_F_ORDER 1
`define ADSF_F_PD 0
`define ADSF_CMD_RST 7'h07

// Result word and output sequence positions.
`define ADSF_RES_BITS 12
`define ADSF_RES_MSB 4'hB
`define ADSF_SIGN_BIT 11
`define ADSF_POS_BITS 5
`define ADSF_POS_STEP 5'h01
`define ADSF_POS_MSB_END 5'h0C
`define ADSF_POS_LSB_END 5'h18

`endif

// ===== hdl/adsf_pkg.sv
package adsf_pkg;

  // Link-side phase of one chip-select frame.
  typedef enum logic [1:0] {
    ADSF_ST_IDLE,
    ADSF_ST_CMD,
    ADSF_ST_DATA
  } adsf_state_t;

endpackage : adsf_pkg

// ===== hdl/adsf_xfer_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsf_cfg.svh"

interface adsf_xfer_if;
  logic [`ADSF_CMD_BITS-1:0] cmd;
  logic cmd_tgl;
  logic [`ADSF_RES_BITS-1:0] snap;
  logic req;
  logic ack;
  modport link (output cmd, output cmd_tgl, output ack, input snap, input req);
  modport core (input cmd, input cmd_tgl, input ack, output snap, output req);
endinterface : adsf_xfer_if

`default_nettype wire

// ===== hdl/adsf_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "adsf_cfg.svh"

module adsf_core (
  // Clock and synchronised reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Chip select pin
  input wire logic i_cs_n,
  // Converter result, same clock
  input wire logic [`ADSF_RES_BITS-1:0] i_adc_code,
  // Link side
  adsf_xfer_if.core x,
  // Converter control
  output logic o_conv_start,
  output logic o_input_mode_select,
  output logic o_odd_sign,
  output logic [1:0] o_channel_select,
  output logic o_polarity_select,
  output logic o_power_down,
  output logic o_system_shutdown_out_n
);
  import adsf_pkg::*;

  logic cs_meta_q, cs_sync_q, cs_prev_q;
  logic tgl_meta_q, tgl_sync_q, tgl_prev_q;
  logic ack_meta_q, ack_sync_q;
  logic req_q;
  logic [`ADSF_RES_BITS-1:0] snap_q;
  logic shut_q;
  logic shut_d;
  wire cs_begin = cs_prev_q & ~cs_sync_q;
  wire cmd_evt = tgl_sync_q ^ tgl_prev_q;
  wire pd_req = cmd_evt & ~x.cmd[`ADSF_F_PD];
  wire snap_free = (ack_sync_q == req_q);

  // A new shutdown request wins over the clear from a starting frame.
  assign shut_d = pd_req | (shut_q & ~cs_begin);
  assign x.snap = snap_q;
  assign x.req = req_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= i_cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      tgl_meta_q <= x.cmd_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
      ack_meta_q <= x.ack;
      ack_sync_q <= ack_meta_q;
    end
  end

  // The snapshot only changes while the link side has acknowledged it.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= 1'b0;
      snap_q <= '0;
    end else if (snap_free) begin
      snap_q <= i_adc_code;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_start <= 1'b0;
      o_input_mode_select <= 1'b0;
      o_odd_sign <= 1'b0;
      o_channel_select <= '0;
      o_polarity_select <= 1'b1;
      shut_q <= 1'b0;
      o_power_down <= 1'b0;
      o_system_shutdown_out_n <= 1'b1;
    end else begin
      o_conv_start <= cmd_evt & x.cmd[`ADSF_F_PD];
      if (cmd_evt) begin
        o_input_mode_select <= x.cmd[`ADSF_F_MODE];
        o_odd_sign <= x.cmd[`ADSF_F_ODD];
        o_channel_select <= x.cmd[`ADSF_F_SEL_HI:`ADSF_F_SEL_LO];
        o_polarity_select <= x.cmd[`ADSF_F_POL];
      end
      shut_q <= shut_d;
      o_power_down <= shut_d;
      o_system_shutdown_out_n <= ~shut_d;
    end
  end

endmodule : adsf_core

`default_nettype wire

// ===== dv/adsf_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adsf_top_monitor (
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  // Link and outputs
  input wire logic i_cs_n,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_conv_start,
  input wire logic o_polarity_select,
  input wire logic o_power_down,
  input wire logic o_system_shutdown_out_n
);
  // Counts driven positions; value 0 marks the null bit, p+1 marks position p.
  logic [5:0] pos_q;
  logic [5:0] pos_d;
  assign pos_d = (o_dout_oe && pos_q != 6'h3F) ? pos_q + 6'h01 : pos_q;
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) pos_q <= 6'h00;
    else pos_q <= pos_d;
  end
  a_oe_cs_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_cs_n |-> !o_dout_oe) else $error("data-out driven while deselected");
  a_sso_pair: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_power_down == !o_system_shutdown_out_n) else $error("shutdown pin mismatch");
  a_sso_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $fell(i_cs_n) |-> ##[1:5] o_system_shutdown_out_n) else $error("shutdown not left");
  a_shut_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !o_system_shutdown_out_n && i_cs_n |=> !o_system_shutdown_out_n)
    else $error("shutdown left while deselected");
  a_conv_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_conv_start |-> !o_power_down ##1 !o_conv_start) else $error("bad start pulse");
  a_dout_steady: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_sclk && $past(i_sclk) && !i_cs_n && !$past(i_cs_n) |-> $stable(o_dout))
    else $error("data-out moved while clock high");
  a_null_zero: assert property (@(posedge i_sclk) disable iff (!i_resetn || i_cs_n)
    o_dout_oe && pos_q == 6'h00 |-> !o_dout) else $error("null bit not zero");
  a_fill_zero: assert property (@(posedge i_sclk) disable iff (!i_resetn || i_cs_n)
    pos_q >= 6'h19 && o_polarity_select |-> !o_dout) else $error("fill not zero");
  a_shut_ones: assert property (@(posedge i_sclk) disable iff (!i_resetn || i_cs_n)
    o_power_down && pos_q >= 6'h01 && pos_q <= 6'h0C |-> o_dout)
    else $error("shutdown word not ones");
  c_conv: cover property (@(posedge i_mclk) o_conv_start);
  c_shut: cover property (@(posedge i_mclk) $rose(o_power_down));
  c_long: cover property (@(posedge i_sclk) pos_q == 6'h1E);
endmodule : adsf_top_monitor
bind adsf_top adsf_top_monitor u_mon (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
  .o_conv_start(o_conv_start), .o_polarity_select(o_polarity_select),
  .o_power_down(o_power_down), .o_system_shutdown_out_n(o_system_shutdown_out_n));
`default_nettype wire

// ===== dv/adsf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module adsf_host_model (
  // Lines driven by the host
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  // Line read by the host
  input wire logic i_dout
);
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_din = 1'h0;
  end
  // Port lines under program control; the clock stands low between frames.
  task automatic xfer(input logic [6:0] cmd, input int lead, input int n,
    output logic [47:0] q);
    int i;
    q = '0;
    o_cs_n <= 1'h0;
    #20;
    for (i = 0; i < n; i++) begin
      if (i <= lead) o_din <= (i == lead);
      else if (i <= lead + 7) o_din <= cmd[lead + 7 - i];
      else o_din <= ~q[i - 1];
      #16 o_sclk <= 1'h1;
      q[i] = i_dout;
      #16 o_sclk <= 1'h0;
    end
    #20 o_cs_n <= 1'h1;
    #40;
  endtask : xfer
endmodule : adsf_host_model
`default_nettype wire

// ===== dv/adsf_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adsf_top_tb;
  logic mclk, resetn, sclk, cs_n, din, dout, oe, conv, mode, odd, pol, pd, sso_n;
  logic [1:0] chsel;
  logic [11:0] code;
  logic [47:0] q;
  int errors, cmp_count;
  // Counts start pulses, so a missing or doubled pulse shows up in the checks.
  int conv_cnt = 0;
  always @(posedge mclk) begin
    if (conv === 1'b1) conv_cnt <= conv_cnt + 1;
  end
  adsf_top dut (.i_mclk(mclk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .o_dout(dout), .o_dout_oe(oe), .i_adc_code(code), .o_conv_start(conv),
    .o_input_mode_select(mode), .o_odd_sign(odd), .o_channel_select(chsel),
    .o_polarity_select(pol), .o_power_down(pd), .o_system_shutdown_out_n(sso_n));
  adsf_host_model h (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // A warm frame first, since the result crosses only while the link clock runs.
  task automatic frame(input logic [6:0] cmd, input int lead, input int n, input bit warm);
    if (warm) h.xfer(cmd, lead, n, q);
    h.xfer(cmd, lead, n, q);
    repeat (8) @(posedge mclk);
  endtask : frame
  task automatic t_mux;
    int m;
    int c0;
    for (m = 0; m < 16; m++) begin
      c0 = conv_cnt;
      frame({m[3:0], 3'h3}, 0, 9, 1'b0);
      check({mode, odd, chsel, pol}, {m[3:0], 1'h0});
      check(conv_cnt - c0, 1);
    end
    $display("test mux done");
  endtask : t_mux
  task automatic t_order(input logic ord, input logic polarity_select, input logic [11:0] c,
    input bit warm);
    logic [47:0] e;
    int p;
    @(posedge mclk) code <= c;
    frame({4'hA, polarity_select, ord, 1'h1}, 0, 40, warm);
    e = '0;
    for (p = 0; p < 31; p++) begin
      if (p < 12) e[p + 9] = c[11 - p];
      else if (!ord && p < 24) e[p + 9] = c[p - 12];
      else if (!ord) e[p + 9] = !polarity_select && c[11];
    end
    check(q[39:8], e[39:8]);
    check({mode, odd, chsel, pol}, {4'hA, polarity_select});
    $display("test order %0b uni %0b done", ord, polarity_select);
  endtask : t_order
  task automatic t_bytes(input logic [11:0] c);
    logic [7:0] b2, b3;
    int k;
    @(posedge mclk) code <= c;
    frame(7'h47, 3, 24, 1'b1);
    for (k = 0; k < 8; k++) begin
      b2[7 - k] = q[8 + k];
      b3[7 - k] = q[16 + k];
    end
    check(b2[3:0], c[11:8]);
    check(b3, c[7:0]);
    $display("test bytes done");
  endtask : t_bytes
  task automatic t_shut(input logic [11:0] c);
    logic [47:0] e;
    int c0;
    @(posedge mclk) code <= c;
    c0 = conv_cnt;
    frame(7'h46, 0, 30, 1'b1);
    check(conv_cnt - c0, 0);
    e = '0;
    e[20:9] = 12'hFFF;
    check(q[29:8], e[29:8]);
    check({pd, sso_n}, 2'h2);
    check(oe, 1'h0);
    repeat (20) @(posedge mclk);
    check({pd, sso_n}, 2'h2);
    t_order(1'h1, 1'h1, c, 1'b0);
    check({pd, sso_n}, 2'h1);
    $display("test shutdown done");
  endtask : t_shut
  initial begin
    resetn = 1'h0;
    code = 12'h000;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    repeat (6) @(posedge mclk);
    check({pd, sso_n, pol, oe, conv}, 5'h0C);
    t_mux();
    t_order(1'h1, 1'h1, 12'hA5C, 1'b1);
    t_order(1'h1, 1'h0, 12'h9C3, 1'b1);
    t_order(1'h0, 1'h1, 12'hA5C, 1'b1);
    t_order(1'h0, 1'h0, 12'h9C3, 1'b1);
    t_bytes(12'h6B9);
    t_shut(12'h35E);
    test_done();
  end
  initial begin
    #150000;
    errors++;
    test_done();
  end
endmodule : adsf_top_tb
`default_nettype wire
